// >>> hw/ssp_pkg.sv
// shared constants, opcodes and types for the status/protect block
`default_nettype none
package ssp_pkg;
  // opcodes, bit 3 masked off before compare
  localparam logic [7:0] SSP_OP_MASK = 8'hF7;
  localparam logic [7:0] SSP_OP_READ_STATUS_CMD = 8'h05;
  localparam logic [7:0] SSP_OP_SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] SSP_OP_CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] SSP_OP_WRITE_STATUS_CMD = 8'h01;
  // bit counts of a complete frame, and the saturation limit of the bit counter
  localparam logic [4:0] SSP_OPC_BITS = 5'h08;
  localparam logic [4:0] SSP_WRITE_STATUS_CMD_BITS = 5'h10;
  localparam logic [4:0] SSP_CNT_MAX = 5'h1F;
  // value after reset
  localparam logic SSP_WEL_RST = 1'b0;
  localparam logic [2:0] SSP_NV_RST = 3'h0;
  // self-timed write cycle
  localparam int SSP_CLK_MHZ = 25;
  localparam int SSP_WC_TIME_US = 5000;
  localparam int SSP_WC_CYCLES = SSP_WC_TIME_US * SSP_CLK_MHZ;
  // frame decoder states
  typedef enum logic [2:0] {
    FR_IDLE = 3'b000,
    FR_OPC = 3'b001,
    FR_DATA = 3'b010,
    FR_READ = 3'b011,
    FR_DONE = 3'b100
  } ssp_frame_e;
  // serial pins as sampled
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } ssp_pins_s;
  // status byte layout
  typedef struct packed {
    logic pin_en;
    logic [2:0] rsv;
    logic [1:0] bpl;
    logic write_enable_latch;
    logic busy;
  } ssp_status_s;
endpackage : ssp_pkg
`default_nettype wire

// >>> hw/ssp_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] d_async,
  output logic [W-1:0] q_sync
);
  logic [W-1:0] meta_reg;

  // first stage read only by second stage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '1;
      q_sync <= '1;
    end else begin
      meta_reg <= d_async;
      q_sync <= meta_reg;
    end
  end
endmodule : ssp_sync
`default_nettype wire

// >>> hw/ssp_wcycle.sv
// self-timed internal write cycle timer
`timescale 1ns/1ps
`default_nettype none
module ssp_wcycle #(
  parameter int CYCLES = 125000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic busy_next;

  // last busy cycle raises done
  assign done = busy && (cnt_reg == ONE);

  // countdown, start ignored while busy
  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy;
    if (busy) begin
      cnt_next = cnt_reg - ONE;
      if (done) begin
        busy_next = 1'b0;
      end
    end else if (start) begin
      cnt_next = LOAD;
      busy_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
      busy <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy <= busy_next;
    end
  end
endmodule : ssp_wcycle
`default_nettype wire

// >>> hw/ssp_top.sv
// status register and write protection of a serial eeprom
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - holds 8-bit status: pin enable, protect level, write latch, busy flag.
// - bits 6:4 read zero when idle, ones during an internal write.
// - busy flag reads 1 during programming, 0 when ready; read only.
// - opcode 05h returns the status byte on serial out, msb first.
// - opcode 06h sets the write latch when chip select rises.
// - write latch is cleared at power-up.
// - opcode 04h clears the write latch regardless of protect pin.
// - status write changes only bits 7, 3 and 2.
// - pin enable and protect level are kept in nonvolatile cells.
// - during the write cycle only status reads act; end clears latch.
// - valid status write starts the internal cycle at chip select rise.
// - 16K part protects 3000h, 2000h or 0000h up to 3FFFh.
// - 32K part protects 6000h, 4000h or 0000h up to 7FFFh.
// - pin low with pin enable set blocks status and protected writes.
// - protection off when pin high or pin enable clear.
// - without hardware protection, status write needs only the latch.
// - protected addresses never written; others need the latch set.
// - pin enable cannot be cleared while pin stays low.
// - opcodes need upper nibble zero; bit 3 is ignored.
// - protect pin falling during a status write frame aborts it.
module ssp_top
  import ssp_pkg::*;
#(
  parameter int ABITS = 15,
  parameter int WC_CYCLES = SSP_WC_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  // nonvolatile cells of pin enable and protect level
  input wire logic [2:0] nv_stored,
  output logic [2:0] nv_store,
  output logic nv_store_stb,
  // array write permission
  input wire logic array_wr_req,
  input wire logic [15:0] array_wr_addr,
  output logic array_wr_grant,
  output logic busy_out
);
  ssp_pins_s pins_raw;
  ssp_pins_s pins_s;
  ssp_status_s stat_live;
  ssp_frame_e fr_reg, fr_next;
  logic sck_d_reg, cs_d_reg, wp_d_reg;
  logic [4:0] cnt_reg, cnt_next;
  logic [7:0] op_reg, op_next;
  logic [7:0] dat_reg, dat_next;
  logic [7:0] snap_reg, snap_next;
  logic [2:0] oidx_reg, oidx_next;
  logic so_next, so_oe_next;
  logic wel_reg, wel_next;
  logic [2:0] nv_reg, nv_next;
  logic nvld_reg, nvld_next;
  logic [2:0] pend_reg, pend_next;
  logic pend_vld_reg, pend_vld_next;
  logic abort_reg, abort_next;
  logic grant_next;
  logic [2:0] nvst_next;
  logic nvst_stb_next;
  logic sck_rise, sck_fall, cs_fall, cs_rise, wp_fall;
  logic hw_prot, blk_prot, spi_start, wc_start, wc_done, busy;
  logic [7:0] opm, opn;
  logic [ABITS-1:0] aaddr;

  // pins cross into the clock domain
  assign pins_raw = '{cs_n: cs_n, sck: sck, si: si, wp_n: wp_n};
  ssp_sync #(.W(4)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .d_async(pins_raw),
    .q_sync(pins_s)
  );

  ssp_wcycle #(.CYCLES(WC_CYCLES)) u_wc (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(wc_start),
    .busy(busy),
    .done(wc_done)
  );

  // edges of synchronised pins
  assign sck_rise = pins_s.sck & ~sck_d_reg;
  assign sck_fall = ~pins_s.sck & sck_d_reg;
  assign cs_fall = ~pins_s.cs_n & cs_d_reg;
  assign cs_rise = pins_s.cs_n & ~cs_d_reg;
  assign wp_fall = ~pins_s.wp_n & wp_d_reg;

  // live status byte
  assign stat_live.pin_en = nv_reg[2];
  assign stat_live.rsv = {3{busy}};
  assign stat_live.bpl = nv_reg[1:0];
  assign stat_live.write_enable_latch = wel_reg;
  assign stat_live.busy = busy;

  // hardware protection needs pin low and pin enable set
  assign hw_prot = nv_reg[2] & ~pins_s.wp_n;

  // protected range by level, same form for both array sizes
  assign aaddr = array_wr_addr[ABITS-1:0];
  always_comb begin
    unique case (nv_reg[1:0])
      2'b00: blk_prot = 1'b0;
      2'b01: blk_prot = &aaddr[ABITS-1 -: 2];
      2'b10: blk_prot = aaddr[ABITS-1];
      2'b11: blk_prot = 1'b1;
    endcase
  end

  // opcode with bit 3 masked
  assign opn = {op_reg[6:0], pins_s.si};
  assign opm = op_reg & SSP_OP_MASK;

  // status write start at chip select rise
  assign spi_start = cs_rise && !busy && (opm == SSP_OP_WRITE_STATUS_CMD)
                     && (cnt_reg == SSP_WRITE_STATUS_CMD_BITS) && wel_reg
                     && !hw_prot && !abort_reg;
  assign wc_start = spi_start | grant_next;

  // frame decoding, latch and nonvolatile shadow
  always_comb begin
    fr_next = fr_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    dat_next = dat_reg;
    snap_next = snap_reg;
    oidx_next = oidx_reg;
    so_next = so;
    so_oe_next = so_oe;
    wel_next = wel_reg;
    nv_next = nv_reg;
    nvld_next = nvld_reg;
    pend_next = pend_reg;
    pend_vld_next = pend_vld_reg;
    abort_next = abort_reg;
    grant_next = 1'b0;
    nvst_next = nv_store;
    nvst_stb_next = 1'b0;
    // pick up stored cells once after reset
    if (!nvld_reg) begin
      nv_next = nv_stored;
      nvld_next = 1'b1;
    end
    // end of internal cycle commits cells and clears latch
    if (wc_done) begin
      wel_next = 1'b0;
      if (pend_vld_reg) begin
        nv_next = pend_reg;
        nvst_next = pend_reg;
        nvst_stb_next = 1'b1;
        pend_vld_next = 1'b0;
      end
    end
    if (cs_fall) begin
      fr_next = FR_OPC;
      cnt_next = '0;
      abort_next = 1'b0;
    end else if (pins_s.cs_n) begin
      fr_next = FR_IDLE;
      so_oe_next = 1'b0;
      so_next = 1'b0;
    end else begin
      if (wp_fall) begin
        abort_next = 1'b1;
      end
      if (sck_rise && fr_reg != FR_READ && fr_reg != FR_IDLE) begin
        cnt_next = (cnt_reg == SSP_CNT_MAX) ? cnt_reg : 5'(cnt_reg + 5'h01);
        if (fr_reg == FR_OPC) begin
          op_next = opn;
          if (cnt_reg == SSP_OPC_BITS - 5'h01) begin
            fr_next = FR_DONE;
            if ((opn & SSP_OP_MASK) == SSP_OP_READ_STATUS_CMD) begin
              fr_next = FR_READ;
              oidx_next = '0;
            end else if ((opn & SSP_OP_MASK) == SSP_OP_WRITE_STATUS_CMD && !busy) begin
              fr_next = FR_DATA;
            end
          end
        end else if (fr_reg == FR_DATA) begin
          dat_next = {dat_reg[6:0], pins_s.si};
        end
      end
      // status shifted out msb first on falling edges
      if (sck_fall && fr_reg == FR_READ) begin
        so_oe_next = 1'b1;
        oidx_next = 3'(oidx_reg + 3'h1);
        if (oidx_reg == 3'h0) begin
          snap_next = stat_live;
          so_next = stat_live.pin_en;
        end else begin
          so_next = snap_reg[3'h7 - oidx_reg];
        end
      end
    end
    // instruction completes when chip select rises
    if (cs_rise && !busy && cnt_reg == SSP_OPC_BITS) begin
      if (opm == SSP_OP_SET_WRITE_LATCH_CMD) begin
        wel_next = 1'b1;
      end else if (opm == SSP_OP_CLEAR_WRITE_LATCH_CMD) begin
        wel_next = 1'b0;
      end
    end
    if (spi_start) begin
      pend_next = {dat_reg[7], dat_reg[3:2]};
      pend_vld_next = 1'b1;
    end
    // array write only outside protected range with latch set
    if (array_wr_req && !busy && !spi_start && wel_reg && !blk_prot) begin
      grant_next = 1'b1;
    end
  end

  // registers of the frame and status state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fr_reg <= FR_IDLE;
      sck_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      wp_d_reg <= 1'b1;
      cnt_reg <= '0;
      op_reg <= '0;
      dat_reg <= '0;
      snap_reg <= '0;
      oidx_reg <= '0;
      so <= 1'b0;
      so_oe <= 1'b0;
      wel_reg <= SSP_WEL_RST;
      nv_reg <= SSP_NV_RST;
      nvld_reg <= 1'b0;
      pend_reg <= SSP_NV_RST;
      pend_vld_reg <= 1'b0;
      abort_reg <= 1'b0;
      array_wr_grant <= 1'b0;
      nv_store <= SSP_NV_RST;
      nv_store_stb <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      fr_reg <= fr_next;
      sck_d_reg <= pins_s.sck;
      cs_d_reg <= pins_s.cs_n;
      wp_d_reg <= pins_s.wp_n;
      cnt_reg <= cnt_next;
      op_reg <= op_next;
      dat_reg <= dat_next;
      snap_reg <= snap_next;
      oidx_reg <= oidx_next;
      so <= so_next;
      so_oe <= so_oe_next;
      wel_reg <= wel_next;
      nv_reg <= nv_next;
      nvld_reg <= nvld_next;
      pend_reg <= pend_next;
      pend_vld_reg <= pend_vld_next;
      abort_reg <= abort_next;
      array_wr_grant <= grant_next;
      nv_store <= nvst_next;
      nv_store_stb <= nvst_stb_next;
      busy_out <= busy | wc_start;
    end
  end

  // checks on latch handling, protection and serial out
  chk_wel_set_set_write_latch_cmd: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cs_rise && !busy && cnt_reg == SSP_OPC_BITS && opm == SSP_OP_SET_WRITE_LATCH_CMD |=> wel_reg)
    else $error("write latch not set by set-latch");
  chk_wel_clr_clear_write_latch_cmd: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cs_rise && !busy && cnt_reg == SSP_OPC_BITS && opm == SSP_OP_CLEAR_WRITE_LATCH_CMD |=> !wel_reg)
    else $error("write latch not cleared by clear-latch");
  chk_wel_cycle_end: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wc_done |=> !wel_reg && !busy)
    else $error("write latch kept after write cycle");
  chk_write_status_cmd_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(pend_vld_reg) |-> $past(wel_reg) && !$past(hw_prot) && $past(cnt_reg) == 5'h10)
    else $error("status write started without permission");
  chk_nv_stable: assert property (@(posedge clk_sys) disable iff (!reset_n)
    nvld_reg && !wc_done |=> $stable(nv_reg))
    else $error("protect bits changed outside write cycle end");
  chk_pin_en_kept: assert property (@(posedge clk_sys) disable iff (!reset_n)
    nvld_reg && hw_prot && !pend_vld_reg |=> nv_reg[2])
    else $error("pin enable cleared under hardware protection");
  chk_read_status_cmd_msb: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sck_fall && fr_reg == FR_READ && oidx_reg == 3'h0 && !pins_s.cs_n
    |=> so == $past(stat_live.pin_en) && so_oe)
    else $error("status msb not driven first");
  chk_abort_wp: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cs_rise && abort_reg && !busy && !array_wr_req |=> !busy ##1 !pend_vld_reg)
    else $error("aborted status write still started");
  chk_grant_prot: assert property (@(posedge clk_sys) disable iff (!reset_n)
    array_wr_grant |-> $past(wel_reg) && !$past(blk_prot))
    else $error("array write granted in protected range");
  chk_so_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pins_s.cs_n |=> !so_oe)
    else $error("serial out driven while deselected");
endmodule : ssp_top
`default_nettype wire

// >>> verification/ssp_spi_master.sv
// mode 0 serial master model that frames transfers to the status block
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_master (
  // time base
  input wire logic clk_sys,
  // serial pins
  output var logic cs_n,
  output var logic sck,
  output var logic si,
  input wire logic so
);
  // idle: deselected, clock low between frames
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // one frame, msb first, 320 ns clock, read bits taken from bit 8 on
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge clk_sys);
    cs_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int i = 0; i < nbits; i++) begin
      sck = 1'b0;
      si = tx[15-i];
      repeat (4) @(negedge clk_sys);
      sck = 1'b1;
      repeat (4) @(negedge clk_sys);
      if (i >= 8) rx = {rx[6:0], so};
    end
    sck = 1'b0;
    repeat (4) @(negedge clk_sys);
    cs_n = 1'b1;
    si = ~si; // released line does not hold its last value
    repeat (8) @(negedge clk_sys);
  endtask : xfer
endmodule : ssp_spi_master
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench of the status register and protection block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ssp_pkg::*;
  localparam int WC = 2000;
  typedef struct packed {
    logic [15:0] tx;
    logic [4:0] nbits;
    logic idle;
    logic [7:0] exp;
  } ssp_row_s;
  // frame sent, bit count, wait for idle, status read back afterwards
  ssp_row_s rows [11] = '{
    '{16'h01ff, 5'h10, 1'b0, 8'h00},
    '{16'h0600, 5'h08, 1'b0, 8'h02},
    '{16'h0400, 5'h08, 1'b0, 8'h00},
    '{16'h0e00, 5'h08, 1'b0, 8'h02},
    '{16'h0c00, 5'h08, 1'b0, 8'h00},
    '{16'h4600, 5'h08, 1'b0, 8'h00},
    '{16'h0600, 5'h07, 1'b0, 8'h00},
    '{16'h0600, 5'h08, 1'b0, 8'h02},
    '{16'h01ff, 5'h10, 1'b0, 8'h73},
    '{16'h0400, 5'h08, 1'b0, 8'h73},
    '{16'h0000, 5'h08, 1'b1, 8'h8c}
  };
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic wp_n = 1'b1;
  logic array_wr_req = 1'b0;
  logic [15:0] array_wr_addr = 16'h0000;
  logic [2:0] nv_cells = 3'h0;
  wire logic cs_n;
  wire logic sck;
  wire logic si;
  logic so;
  logic so_oe;
  logic [2:0] nv_store;
  logic nv_store_stb;
  logic array_wr_grant;
  logic busy_out;
  int err_total = 0;
  int num_checks = 0;
  logic [7:0] rx;
  // clock
  always #20 clk_sys = ~clk_sys;
  // design and far-side master
  ssp_top #(.ABITS(15), .WC_CYCLES(WC)) ssp_top_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .so(so), .so_oe(so_oe), .nv_stored(nv_cells), .nv_store(nv_store),
    .nv_store_stb(nv_store_stb), .array_wr_req(array_wr_req),
    .array_wr_addr(array_wr_addr), .array_wr_grant(array_wr_grant), .busy_out(busy_out)
  );
  ssp_spi_master ssp_spi_master_inst (
    .clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si), .so(so)
  );
  // nonvolatile cells keep what was programmed, across resets too
  always @(posedge clk_sys) if (nv_store_stb === 1'b1) nv_cells <= nv_store;
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // frame without read-back
  task automatic send(input logic [15:0] tx);
    logic [7:0] d;
    ssp_spi_master_inst.xfer(tx, tx[7:0] == 8'h00 ? 8 : 16, d);
  endtask : send
  // status read frame
  task automatic read_status_cmd(input logic [7:0] exp);
    ssp_spi_master_inst.xfer(16'h0500, 16, rx);
    check("status", rx, exp);
  endtask : read_status_cmd
  // bounded wait for the internal cycle to end
  task automatic wait_idle;
    for (int i = 0; i < 2 * WC && busy_out !== 1'b0; i++) @(negedge clk_sys);
    check("busy_out", {7'h00, busy_out}, 8'h00);
  endtask : wait_idle
  // hold an array request three cycles and count grants
  task automatic arr(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] g;
    g = 8'h00;
    @(negedge clk_sys);
    array_wr_addr = a;
    array_wr_req = 1'b1;
    repeat (3) begin
      @(negedge clk_sys);
      if (array_wr_grant === 1'b1) g++;
    end
    array_wr_req = 1'b0;
    check("grant", g, exp);
  endtask : arr
  // verdict
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // watchdog
  initial begin
    #2000000;
    err_total++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    check("so_oe", {7'h00, so_oe}, 8'h00);
    read_status_cmd(8'h00);
    foreach (rows[k]) begin
      ssp_spi_master_inst.xfer(rows[k].tx, int'(rows[k].nbits), rx);
      if (rows[k].idle) wait_idle();
      read_status_cmd(rows[k].exp);
    end
    check("nv cells", {5'h00, nv_cells}, 8'h07);
    // whole array protected
    send(16'h0600);
    arr(16'h0000, 8'h00);
    read_status_cmd(8'h8e);
    // hardware protection blocks status writes, not the clear
    wp_n = 1'b0;
    ssp_spi_master_inst.xfer(16'h0100, 16, rx);
    check("busy_out", {7'h00, busy_out}, 8'h00);
    read_status_cmd(8'h8e);
    send(16'h0400);
    read_status_cmd(8'h8c);
    // pin high: latch alone permits the write
    wp_n = 1'b1;
    send(16'h0600);
    send(16'h0104);
    wait_idle();
    read_status_cmd(8'h04);
    // quarter protection of the 32K range
    send(16'h0600);
    arr(16'h6000, 8'h00);
    arr(16'h5fff, 8'h01);
    wait_idle();
    read_status_cmd(8'h04);
    arr(16'h0000, 8'h00);
    // pin falling inside a status write frame aborts it
    send(16'h0600);
    fork
      send(16'h010c);
      begin
        repeat (60) @(negedge clk_sys);
        wp_n = 1'b0;
      end
    join
    wp_n = 1'b1;
    check("busy_out", {7'h00, busy_out}, 8'h00);
    send(16'h0400);
    read_status_cmd(8'h04);
    // second reset: latch clears, stored bits return
    send(16'h0600);
    reset_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    read_status_cmd(8'h04);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
